// [logic/mac_filter_pkg.sv]
package mac_filter_pkg;
    localparam int ADDR_W = 48;
    localparam int DA_BYTES = 6;
    localparam int MCAST_NUM = 4;
    localparam int STRAP_CFG_W = 65;
    localparam int STRAP_PROMISC_BIT = 64;
    localparam int PROMISC_BIT = 31;
    localparam logic [47:0] BROADCAST_ADDR = 48'hFFFF_FFFF_FFFF;
    localparam logic [47:0] PAUSE_MCAST_ADDR = 48'h0100_00C2_8001;
    localparam logic [47:0] MCAST_RESET = 48'h0000_0000_0000;
    localparam logic [15:0] CTRL_TYPE = 16'h8808;
    localparam logic [15:0] PAUSE_OPCODE = 16'h0001;
    localparam logic [10:0] CTRL_FRAME_BYTES = 11'h040;
    localparam logic [5:0] PAUSE_FRAME_LAST = 6'h3B;
    localparam int RX_DELAY = 7;
    localparam logic [10:0] DECIDE_BYTE = 11'h006;
    localparam logic [10:0] TYPE_HI = 11'h00C;
    localparam logic [10:0] OPCODE_HI = 11'h00E;
    localparam logic [10:0] QUANTA_HI = 11'h010;
    localparam logic [3:0] SEL_UNICAST = 4'h0;
    localparam logic [3:0] SEL_MCAST0 = 4'h1;
    localparam logic [3:0] SEL_PAUSE_SRC = 4'h5;
    localparam logic [3:0] SEL_MODE = 4'h6;
    localparam logic [1:0] SPEED_10 = 2'h0;
    localparam logic [1:0] SPEED_100 = 2'h1;
    localparam int CLK_PERIOD_NS = 20;
    localparam int BITS_PER_QUANTUM = 512;
    localparam int QUANTUM_NS_1G = BITS_PER_QUANTUM * 1;
    localparam int QUANTUM_NS_100M = BITS_PER_QUANTUM * 10;
    localparam int QUANTUM_NS_10M = BITS_PER_QUANTUM * 100;
    localparam int Q_CYC_1G = (QUANTUM_NS_1G + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int Q_CYC_100M = (QUANTUM_NS_100M + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int Q_CYC_10M = (QUANTUM_NS_10M + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef enum logic [1:0] {TX_IDLE, TX_CLIENT, TX_PAUSE} tx_state_type;
endpackage : mac_filter_pkg

// [logic/dest_addr_match.sv]
`timescale 1ns/1ps
module dest_addr_match (
    input wire logic [47:0] da_in,
    input wire logic [47:0] unicast_in,
    input wire logic [47:0] mcast_in [mac_filter_pkg::MCAST_NUM],
    input wire logic [47:0] pause_src_in,
    output logic accept_out,
    output logic pause_da_out
);
    logic [mac_filter_pkg::MCAST_NUM-1:0] mc_hit;

    genvar i;
    generate
        for (i = 0; i < mac_filter_pkg::MCAST_NUM; i++) begin : g_mc
            // An unprogrammed all-zero entry never matches
            assign mc_hit[i] = (mcast_in[i] != mac_filter_pkg::MCAST_RESET)
                && (da_in == mcast_in[i]);
        end
    endgenerate

    // Broadcast and pause addresses are fixed; unicast and multicast programmable
    assign accept_out = (da_in == unicast_in) || (|mc_hit)
        || (da_in == mac_filter_pkg::BROADCAST_ADDR)
        || (da_in == mac_filter_pkg::PAUSE_MCAST_ADDR);
    assign pause_da_out = (da_in == mac_filter_pkg::PAUSE_MCAST_ADDR)
        || (da_in == pause_src_in);
endmodule : dest_addr_match

// [logic/pause_hold_timer.sv]
`timescale 1ns/1ps
module pause_hold_timer (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic load_in,
    input wire logic [15:0] quanta_in,
    input wire logic [1:0] speed_in,
    output logic paused_out
);
    logic [15:0] left_ff;
    logic [12:0] tick_ff;
    logic [12:0] per_q;

    always_comb begin
        case (speed_in)
            mac_filter_pkg::SPEED_10: per_q = 13'(mac_filter_pkg::Q_CYC_10M);
            mac_filter_pkg::SPEED_100: per_q = 13'(mac_filter_pkg::Q_CYC_100M);
            default: per_q = 13'(mac_filter_pkg::Q_CYC_1G);
        endcase
    end

    // One quantum is 512 bit times at the current rate; zero cancels at once
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            left_ff <= 16'h0000;
            tick_ff <= 13'h0000;
        end else if (load_in) begin
            left_ff <= quanta_in;
            tick_ff <= 13'h0000;
        end else if (left_ff != 16'h0000) begin
            if (tick_ff >= per_q - 13'h0001) begin
                tick_ff <= 13'h0000;
                left_ff <= left_ff - 16'h0001;
            end else begin
                tick_ff <= tick_ff + 13'h0001;
            end
        end
    end

    assign paused_out = (left_ff != 16'h0000);
endmodule : pause_hold_timer

// [logic/mac_filter_flow.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - Filtering on: forward a frame only if its destination address is acceptable.
// - Filtering off: forward every received frame.
// - Broadcast and pause addresses fixed; unicast and multicast programmable.
// - Software switches filtering off by setting promiscuous bit 31 in the mode register.
// - Filter on: valid/reject codes none, rejected, passed; never both high.
// - Filter off: valid alone matches, both high is non-match; reject alone never.
// - Reject flag marks any non-matching frame in either mode.
// - Station address strap presets unicast address.
// - Config strap presets pause source address and promiscuous bit 31.
// - Straps never preset the four multicast entries.
// - Host writes can replace every filter register value.
// - Transmit and receive pause handling enabled separately.
// - Pause frame waits for current frame, goes before waiting frames.
// - Pause frame is sent even while transmitter is paused.
// - Pause frame carries pause address and captured quanta.
// - Compare destination with control multicast and station source address.
// - Opcode compared only when type equals control type.
// - Failed checks or receive pause disabled: frame delivered normally.
// - Valid 64-byte pause with receive pause enabled holds off transmitter.
// - Acted-upon pause frame delivered with bad flag set.
// - Hardwired pause multicast address is 01-80-C2-00-00-01.
// - Control-type frame not 64 bytes is flagged bad and ignored.
module mac_filter_flow (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [47:0] strap_station_address,
    input wire logic [64:0] strap_config_vector,
    input wire logic host_wr_in,
    input wire logic [3:0] host_sel_in,
    input wire logic [47:0] host_wdata_in,
    input wire logic tx_fc_enable_in,
    input wire logic rx_fc_enable_in,
    input wire logic [1:0] line_speed_in,
    input wire logic [7:0] rx_data_in,
    input wire logic rx_dv_in,
    input wire logic rx_err_in,
    input wire logic pause_request_in,
    input wire logic [15:0] pause_quanta_in,
    input wire logic [7:0] tx_data_in,
    input wire logic tx_valid_in,
    output logic [7:0] rx_data_out,
    output logic rx_data_valid_out,
    output logic rx_frame_reject_flag,
    output logic rx_frame_bad_flag,
    output logic promisc_out,
    output logic tx_ready_out,
    output logic [7:0] tx_data_out,
    output logic tx_en_out,
    output logic tx_paused_out,
    output logic pause_pending_out
);
    localparam int DLY = mac_filter_pkg::RX_DELAY;

    logic [1:0] rst_sync_ff;
    logic rst_n;
    logic init_done_ff;
    logic [47:0] unicast_ff;
    logic [47:0] mcast_ff [mac_filter_pkg::MCAST_NUM];
    logic [47:0] pause_src_ff;
    logic promisc_ff;
    logic [10:0] rx_cnt_ff;
    logic rx_dv_d_ff;
    logic [47:0] da_ff;
    logic [15:0] type_ff;
    logic [15:0] op_ff;
    logic [15:0] rq_ff;
    logic rx_err_ff;
    logic match_ff;
    logic promisc_frame_ff;
    logic bad_ff;
    logic [8:0] dly_ff [DLY];
    logic dly_last_ff;
    logic accept;
    logic pause_da;
    logic rx_end;
    logic ctrl_len_bad;
    logic pause_act;
    logic timer_paused;
    logic dly_dv;
    mac_filter_pkg::tx_state_type state_ff;
    mac_filter_pkg::tx_state_type nxt_state;
    logic pend_ff;
    logic [15:0] pend_q_ff;
    logic [5:0] pcnt_ff;
    logic pause_last;
    logic nxt_pend;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // Straps are caught on the first cycle after release, then host writes win
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            init_done_ff <= 1'b0;
            unicast_ff <= 48'h0000_0000_0000;
            pause_src_ff <= 48'h0000_0000_0000;
            promisc_ff <= 1'b0;
            for (int i = 0; i < mac_filter_pkg::MCAST_NUM; i++) begin
                mcast_ff[i] <= mac_filter_pkg::MCAST_RESET;
            end
        end else if (!init_done_ff) begin
            init_done_ff <= 1'b1;
            unicast_ff <= strap_station_address;
            pause_src_ff <= strap_config_vector[47:0];
            promisc_ff <= strap_config_vector[mac_filter_pkg::STRAP_PROMISC_BIT];
        end else if (host_wr_in) begin
            case (host_sel_in)
                mac_filter_pkg::SEL_UNICAST: unicast_ff <= host_wdata_in;
                mac_filter_pkg::SEL_PAUSE_SRC: pause_src_ff <= host_wdata_in;
                mac_filter_pkg::SEL_MODE: promisc_ff <= host_wdata_in[mac_filter_pkg::PROMISC_BIT];
                default: begin
                    for (int i = 0; i < mac_filter_pkg::MCAST_NUM; i++) begin
                        if (host_sel_in == mac_filter_pkg::SEL_MCAST0 + 4'(i)) begin
                            mcast_ff[i] <= host_wdata_in;
                        end
                    end
                end
            endcase
        end
    end

    dest_addr_match u_match (
        .da_in(da_ff),
        .unicast_in(unicast_ff),
        .mcast_in(mcast_ff),
        .pause_src_in(pause_src_ff),
        .accept_out(accept),
        .pause_da_out(pause_da)
    );

    // Field capture; destination address is assembled first byte lowest
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_cnt_ff <= 11'h000;
            rx_dv_d_ff <= 1'b0;
            da_ff <= 48'h0000_0000_0000;
            type_ff <= 16'h0000;
            op_ff <= 16'h0000;
            rq_ff <= 16'h0000;
            rx_err_ff <= 1'b0;
        end else begin
            rx_dv_d_ff <= rx_dv_in;
            if (rx_dv_in) begin
                if (rx_cnt_ff != 11'h7FF) begin
                    rx_cnt_ff <= rx_cnt_ff + 11'h001;
                end
                if (rx_cnt_ff < 11'(mac_filter_pkg::DA_BYTES)) begin
                    da_ff <= {rx_data_in, da_ff[47:8]};
                end
                if (rx_cnt_ff == mac_filter_pkg::TYPE_HI) type_ff[15:8] <= rx_data_in;
                if (rx_cnt_ff == mac_filter_pkg::TYPE_HI + 11'h001) type_ff[7:0] <= rx_data_in;
                if (rx_cnt_ff == mac_filter_pkg::OPCODE_HI) op_ff[15:8] <= rx_data_in;
                if (rx_cnt_ff == mac_filter_pkg::OPCODE_HI + 11'h001) op_ff[7:0] <= rx_data_in;
                if (rx_cnt_ff == mac_filter_pkg::QUANTA_HI) rq_ff[15:8] <= rx_data_in;
                if (rx_cnt_ff == mac_filter_pkg::QUANTA_HI + 11'h001) rq_ff[7:0] <= rx_data_in;
                rx_err_ff <= rx_err_ff | rx_err_in;
            end else begin
                rx_cnt_ff <= 11'h000;
                rx_err_ff <= 1'b0;
            end
        end
    end

    assign rx_end = rx_dv_d_ff && !rx_dv_in;
    assign ctrl_len_bad = (type_ff == mac_filter_pkg::CTRL_TYPE)
        && (rx_cnt_ff != mac_filter_pkg::CTRL_FRAME_BYTES);
    // Opcode only counts behind a control type; failures leave the frame alone
    assign pause_act = rx_end && !rx_err_ff && rx_fc_enable_in && pause_da
        && (type_ff == mac_filter_pkg::CTRL_TYPE)
        && (op_ff == mac_filter_pkg::PAUSE_OPCODE)
        && (rx_cnt_ff == mac_filter_pkg::CTRL_FRAME_BYTES);

    // Decision is latched once the address is in; the delay line hides the wait
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            match_ff <= 1'b0;
            promisc_frame_ff <= 1'b0;
            bad_ff <= 1'b0;
        end else begin
            if (rx_dv_in && rx_cnt_ff == mac_filter_pkg::DECIDE_BYTE) begin
                match_ff <= accept;
                promisc_frame_ff <= promisc_ff;
            end
            if (rx_end) begin
                bad_ff <= rx_err_ff || pause_act || ctrl_len_bad
                    || (rx_cnt_ff < mac_filter_pkg::CTRL_FRAME_BYTES);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DLY; i++) begin
                dly_ff[i] <= 9'h000;
            end
            dly_last_ff <= 1'b0;
        end else begin
            dly_ff[0] <= {rx_dv_in, rx_data_in};
            for (int i = 1; i < DLY; i++) begin
                dly_ff[i] <= dly_ff[i-1];
            end
            dly_last_ff <= dly_ff[DLY-1][8];
        end
    end
    assign dly_dv = dly_ff[DLY-1][8];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_data_out <= 8'h00;
            rx_data_valid_out <= 1'b0;
            rx_frame_reject_flag <= 1'b0;
            rx_frame_bad_flag <= 1'b0;
            promisc_out <= 1'b0;
        end else begin
            rx_data_out <= dly_ff[DLY-1][7:0];
            rx_data_valid_out <= dly_dv && (match_ff || promisc_frame_ff);
            rx_frame_reject_flag <= dly_dv && !match_ff;
            rx_frame_bad_flag <= dly_last_ff && !dly_dv && bad_ff;
            promisc_out <= promisc_ff;
        end
    end

    pause_hold_timer u_timer (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .load_in(pause_act),
        .quanta_in(rq_ff),
        .speed_in(line_speed_in),
        .paused_out(timer_paused)
    );

    // One pending request at a time; the quanta stays frozen until sent
    assign pause_last = (state_ff == mac_filter_pkg::TX_PAUSE)
        && (pcnt_ff == mac_filter_pkg::PAUSE_FRAME_LAST);
    assign nxt_pend = (pend_ff && !pause_last)
        || (!pend_ff && pause_request_in && tx_fc_enable_in);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_ff <= 1'b0;
            pend_q_ff <= 16'h0000;
        end else begin
            pend_ff <= nxt_pend;
            if (!pend_ff && pause_request_in && tx_fc_enable_in) begin
                pend_q_ff <= pause_quanta_in;
            end
        end
    end

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            mac_filter_pkg::TX_IDLE: begin
                if (pend_ff) begin
                    nxt_state = mac_filter_pkg::TX_PAUSE;
                end else if (tx_valid_in && tx_ready_out) begin
                    nxt_state = mac_filter_pkg::TX_CLIENT;
                end
            end
            mac_filter_pkg::TX_CLIENT: begin
                if (!tx_valid_in) begin
                    nxt_state = pend_ff ? mac_filter_pkg::TX_PAUSE : mac_filter_pkg::TX_IDLE;
                end
            end
            mac_filter_pkg::TX_PAUSE: begin
                if (pause_last) begin
                    nxt_state = mac_filter_pkg::TX_IDLE;
                end
            end
            default: nxt_state = mac_filter_pkg::TX_IDLE;
        endcase
    end

    function automatic logic [7:0] pause_byte(input logic [5:0] idx, input logic [47:0] sa,
                                              input logic [15:0] q);
        logic [7:0] b;
        b = 8'h00;
        if (idx < 6'h06) begin
            b = mac_filter_pkg::PAUSE_MCAST_ADDR[idx[2:0]*8 +: 8];
        end else if (idx < 6'h0C) begin
            b = sa[3'(idx - 6'h06)*8 +: 8];
        end else begin
            case (idx)
                6'h0C: b = mac_filter_pkg::CTRL_TYPE[15:8];
                6'h0D: b = mac_filter_pkg::CTRL_TYPE[7:0];
                6'h0E: b = mac_filter_pkg::PAUSE_OPCODE[15:8];
                6'h0F: b = mac_filter_pkg::PAUSE_OPCODE[7:0];
                6'h10: b = q[15:8];
                6'h11: b = q[7:0];
                default: b = 8'h00;
            endcase
        end
        return b;
    endfunction : pause_byte

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= mac_filter_pkg::TX_IDLE;
            pcnt_ff <= 6'h00;
            tx_ready_out <= 1'b0;
            tx_data_out <= 8'h00;
            tx_en_out <= 1'b0;
            tx_paused_out <= 1'b0;
            pause_pending_out <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            pcnt_ff <= (state_ff == mac_filter_pkg::TX_PAUSE && !pause_last) ?
                pcnt_ff + 6'h01 : 6'h00;
            // Held-off transmitter refuses new client frames via ready
            tx_ready_out <= (nxt_state == mac_filter_pkg::TX_CLIENT)
                || (nxt_state == mac_filter_pkg::TX_IDLE && !nxt_pend && !timer_paused);
            tx_paused_out <= timer_paused;
            pause_pending_out <= nxt_pend;
            if (state_ff == mac_filter_pkg::TX_PAUSE) begin
                tx_en_out <= 1'b1;
                tx_data_out <= pause_byte(pcnt_ff, pause_src_ff, pend_q_ff);
            end else begin
                tx_en_out <= (nxt_state == mac_filter_pkg::TX_CLIENT);
                tx_data_out <= tx_data_in;
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    never_both_a: assert property (!promisc_frame_ff && rx_frame_reject_flag
        |-> !rx_data_valid_out) else $error("valid and reject both high while filtering");
    promisc_code_a: assert property (rx_frame_reject_flag && $past(promisc_frame_ff)
        |-> rx_data_valid_out) else $error("reject alone in promiscuous mode");
    miss_reject_a: assert property (dly_dv && !match_ff |=> rx_frame_reject_flag)
        else $error("non-matching frame not flagged");
    filter_drop_a: assert property (dly_dv && !match_ff && !promisc_frame_ff
        |=> !rx_data_valid_out) else $error("filtered frame forwarded");
    promisc_pass_a: assert property (dly_dv && promisc_frame_ff |=> rx_data_valid_out)
        else $error("promiscuous frame not forwarded");
    strap_load_a: assert property ($rose(init_done_ff) |-> unicast_ff == $past(strap_station_address)
        && pause_src_ff == $past(strap_config_vector[47:0])) else $error("straps not loaded");
    no_cut_a: assert property (state_ff == mac_filter_pkg::TX_CLIENT && tx_valid_in
        |=> state_ff == mac_filter_pkg::TX_CLIENT) else $error("client frame cut short");
    pause_first_a: assert property (state_ff == mac_filter_pkg::TX_IDLE && pend_ff
        |=> state_ff == mac_filter_pkg::TX_PAUSE) else $error("pause frame not started");
    pause_time_a: assert property (state_ff == mac_filter_pkg::TX_PAUSE && pcnt_ff == 6'h10
        |=> tx_data_out == pend_q_ff[15:8] ##1 tx_data_out == pend_q_ff[7:0])
        else $error("pause time field wrong");
    hold_off_a: assert property (pause_act && rq_ff != 16'h0000
        |-> ##2 tx_paused_out ##1 !tx_ready_out) else $error("pause not honoured");
    ctrl_bad_a: assert property (rx_end && ctrl_len_bad |=> bad_ff)
        else $error("short control frame not bad");

    pass_c: cover property (rx_data_valid_out && !rx_frame_reject_flag);
    reject_c: cover property (!rx_data_valid_out && rx_frame_reject_flag);
    pause_tx_c: cover property (pause_last);
    pause_rx_c: cover property (pause_act);
endmodule : mac_filter_flow

// [bench/link_peer_model.sv]
`timescale 1ns/1ps
module link_peer_model (
    input wire logic sys_clk,
    input wire logic err_in,
    output logic [7:0] rx_data_in,
    output logic rx_dv_in,
    output logic rx_err_in
);
    initial begin
        rx_data_in = 8'h5A;
        rx_dv_in = 1'b0;
        rx_err_in = 1'b0;
    end
    // Bytes go out just after each edge; the line shows the inverse once released
    task automatic send(input logic [47:0] da, input logic [15:0] ty, input logic [15:0] q,
                        input int len);
        logic [7:0] b;
        for (int i = 0; i < len; i++) begin
            b = 8'h00;
            if (i < 6) b = da[8*i +: 8];
            if (i == 12) b = ty[15:8];
            if (i == 13) b = ty[7:0];
            if (i == 15) b = 8'h01;
            if (i == 16) b = q[15:8];
            if (i == 17) b = q[7:0];
            rx_data_in = b;
            rx_dv_in = 1'b1;
            rx_err_in = err_in && (i == 20);
            @(posedge sys_clk);
            #1;
        end
        rx_dv_in = 1'b0;
        rx_err_in = 1'b0;
        rx_data_in = ~b;
    endtask : send
endmodule : link_peer_model

// [bench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    localparam logic [47:0] STA = 48'h5544_3322_1100;
    localparam logic [47:0] OTH = 48'h0A0B_0C0D_0E02;
    localparam logic [47:0] PM = mac_filter_pkg::PAUSE_MCAST_ADDR;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic host_wr_in = 1'b0;
    logic [3:0] host_sel_in = 4'h0;
    logic [47:0] host_wdata_in = 48'h0;
    logic tx_fc_enable_in = 1'b0;
    logic rx_fc_enable_in = 1'b0;
    logic [1:0] line_speed_in = 2'h2;
    logic pause_request_in = 1'b0;
    logic [15:0] pause_quanta_in = 16'h0;
    logic tx_valid_in = 1'b0;
    logic [7:0] tx_data_in = 8'h00;
    logic link_err = 1'b0;
    logic [7:0] rx_data_in, tx_data_out, rx_data_out;
    logic rx_dv_in, rx_err_in, rx_data_valid_out, rx_frame_reject_flag, rx_frame_bad_flag;
    logic promisc_out, tx_ready_out, tx_en_out, tx_paused_out, pause_pending_out;
    int n_mismatch = 0;
    int n_tests = 0;
    always #10 sys_clk = ~sys_clk;
    link_peer_model peer_u (.sys_clk(sys_clk), .err_in(link_err), .rx_data_in(rx_data_in),
        .rx_dv_in(rx_dv_in),
        .rx_err_in(rx_err_in));
    // Both straps carry the station address; filter starts enabled
    mac_filter_flow dut_u (.sys_clk(sys_clk), .rstn(rstn), .strap_station_address(STA),
        .strap_config_vector({17'h0, STA}),
        .host_wr_in(host_wr_in), .host_sel_in(host_sel_in),
        .host_wdata_in(host_wdata_in), .tx_fc_enable_in(tx_fc_enable_in),
        .rx_fc_enable_in(rx_fc_enable_in), .line_speed_in(line_speed_in),
        .rx_data_in(rx_data_in), .rx_dv_in(rx_dv_in), .rx_err_in(rx_err_in),
        .pause_request_in(pause_request_in), .pause_quanta_in(pause_quanta_in),
        .tx_data_in(tx_data_in), .tx_valid_in(tx_valid_in), .rx_data_out(rx_data_out),
        .rx_data_valid_out(rx_data_valid_out),
        .rx_frame_reject_flag(rx_frame_reject_flag), .rx_frame_bad_flag(rx_frame_bad_flag),
        .promisc_out(promisc_out), .tx_ready_out(tx_ready_out), .tx_data_out(tx_data_out),
        .tx_en_out(tx_en_out), .tx_paused_out(tx_paused_out),
        .pause_pending_out(pause_pending_out));
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic results();
        if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : results
    task automatic host_write(input logic [3:0] sel, input logic [47:0] d);
        host_sel_in = sel;
        host_wdata_in = d;
        host_wr_in = 1'b1;
        @(posedge sys_clk);
        #1;
        host_wr_in = 1'b0;
        @(posedge sys_clk);
        #1;
    endtask : host_write
    // Expected {valid, reject} at the second output byte and bad at the pulse cycle
    task automatic rx_frame(input logic [47:0] da, input logic [15:0] ty, input logic [15:0] q,
                            input int len, input logic [2:0] exp);
        fork
            peer_u.send(da, ty, q, len);
            begin
                repeat (9) @(posedge sys_clk);
                #1;
                check({rx_data_valid_out, rx_frame_reject_flag}, exp[2:1]);
                check(rx_data_out, da[15:8]);
                repeat (len - 1) @(posedge sys_clk);
                #1;
                check(rx_frame_bad_flag, exp[0]);
            end
        join
        repeat (10) @(posedge sys_clk);
        #1;
    endtask : rx_frame
    // A second request while pending must not add a frame
    task automatic tx_pause(input logic [15:0] q);
        logic [7:0] got [60];
        int n;
        n = 0;
        tx_fc_enable_in = 1'b1;
        pause_quanta_in = q;
        pause_request_in = 1'b1;
        @(posedge sys_clk);
        #1;
        check(pause_pending_out, 1'b1);
        for (int c = 0; c < 80; c++) begin
            pause_request_in = (c == 3);
            pause_quanta_in = 16'hBEEF;
            @(posedge sys_clk);
            #1;
            if (tx_en_out === 1'b1 && n < 60) got[n] = tx_data_out;
            if (tx_en_out === 1'b1) n++;
        end
        check(n, 60);
        check({got[0], got[1], got[2], got[5]}, 32'h0180_C201);
        check({got[7], got[6], got[12], got[13]}, 32'h1100_8808);
        check({got[16], got[17]}, q);
    endtask : tx_pause
    // Pause asked for mid-frame waits for the frame's end, then goes out once
    task automatic tx_client();
        int n;
        n = 0;
        for (int c = 0; c < 80; c++) begin
            tx_valid_in = (c < 8);
            tx_data_in = 8'hA0 + 8'(c);
            pause_request_in = (c == 2);
            pause_quanta_in = 16'h0007;
            @(posedge sys_clk);
            #1;
            if (tx_en_out === 1'b1) n++;
            if (c == 4) check(tx_ready_out, 1'b1);
            if (c == 7) check({tx_en_out, tx_data_out}, 9'h1A7);
            if (c == 8) check(tx_en_out, 1'b0);
            if (c == 9) check(tx_data_out, 8'h01);
            if (c == 26) check(tx_data_out, 8'h07);
        end
        check(n, 68);
    endtask : tx_client
    initial begin
        #(20 * 6000);
        n_mismatch++;
        results();
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        #1;
        rstn = 1'b1;
        repeat (5) @(posedge sys_clk);
        #1;
        check(promisc_out, 1'b0);
        rx_frame(STA, 16'h0800, 16'h0, 64, 3'b100);
        rx_frame(OTH, 16'h0800, 16'h0, 64, 3'b010);
        rx_frame(48'hFFFF_FFFF_FFFF, 16'h0800, 16'h0, 64, 3'b100);
        host_write(mac_filter_pkg::SEL_MCAST0, OTH);
        rx_frame(OTH, 16'h0800, 16'h0, 64, 3'b100);
        host_write(mac_filter_pkg::SEL_UNICAST, 48'h0000_0000_0E04);
        rx_frame(STA, 16'h0800, 16'h0, 64, 3'b010);
        rx_frame(OTH, 16'h8808, 16'h0, 70, 3'b101);
        rx_frame(PM, 16'h8808, 16'h0002, 64, 3'b100);
        check(tx_paused_out, 1'b0);
        rx_fc_enable_in = 1'b1;
        link_err = 1'b1;
        rx_frame(PM, 16'h8808, 16'h0002, 64, 3'b101);
        link_err = 1'b0;
        check(tx_paused_out, 1'b0);
        rx_frame(PM, 16'h8808, 16'h0002, 64, 3'b101);
        check({tx_paused_out, tx_ready_out}, 2'b10);
        tx_pause(16'h1234);
        check(tx_paused_out, 1'b0);
        host_write(mac_filter_pkg::SEL_MODE, 48'h0000_8000_0000);
        check(promisc_out, 1'b1);
        rx_frame(STA, 16'h0800, 16'h0, 64, 3'b110);
        rx_frame(STA, 16'h8808, 16'hFFFF, 64, 3'b111);
        check(tx_paused_out, 1'b1);
        rx_frame(PM, 16'h8808, 16'h0000, 64, 3'b101);
        check(tx_paused_out, 1'b0);
        tx_client();
        line_speed_in = mac_filter_pkg::SPEED_100;
        rx_frame(PM, 16'h8808, 16'h0001, 64, 3'b101);
        repeat (230) @(posedge sys_clk);
        #1;
        check(tx_paused_out, 1'b1);
        repeat (20) @(posedge sys_clk);
        #1;
        check(tx_paused_out, 1'b0);
        results();
    end
endmodule : tb_top
